// file: rtl/lrc_ctrl.v
// linear regulator enable, level, mode, discharge and overcurrent control
`timescale 1ns/1ns
`include "lrc_map.vh"
module lrc_ctrl #(
	parameter OC_DB_NS = `LRC_OC_DB_NS,
	parameter CNT_W = 12,
	parameter MV_W = 10
) (
	// clock and asynchronous reset
	input wire core_clk_i,
	input wire arst_n_i,
	// host control images and the mode pin
	input wire power_mode_pin_i,
	input wire [47:0] primary_ctrl_reg_i,
	input wire [47:0] alternate_ctrl_reg_i,
	// sequencer ownership and non-volatile defaults
	input wire seq_active_i,
	input wire [5:0] seq_on_i,
	input wire nvm_load_i,
	input wire [11:0] nvm_default_level_i,
	input wire nvm_switch_default_i,
	// discharge inhibit bits, high keeps the discharge off
	input wire [3:0] discharge_ctrl_a_i,
	input wire [2:0] discharge_ctrl_b_i,
	// memory reference enable and raw analog flags
	input wire memref_on_i,
	input wire [5:0] oc_source_i,
	input wire mm_sink_oc_i,
	input wire memref_limit_i,
	// phy supply readings, already on this clock
	input wire [MV_W-1:0] phy_vin_mv_i,
	input wire [MV_W-1:0] phy_vbus_mv_i,
	input wire [MV_W-1:0] phy_boost_mv_i,
	// per-regulator controls
	output reg [5:0] reg_enable_o,
	output reg [29:0] level_code_o,
	output reg [71:0] level_mv_o,
	output reg alt_mode_o,
	output reg mm_bypass_o,
	output reg mm_sink_source_o,
	output reg [6:0] discharge_o,
	// interrupts and status
	output reg [5:0] overcurrent_irq_o,
	output reg memref_limit_o,
	output reg [1:0] phy_supply_source_o,
	output reg [7:0] restart_status_reg_o
);

	// debounce length in cycles, rounded up so the filter is never shorter than asked
	localparam integer DB_CYC_N = (OC_DB_NS * `LRC_CLK_MHZ + 999) / 1000;
	// counter constants are cut to the counter width on purpose
	localparam [CNT_W-1:0] DB_CYC = DB_CYC_N[CNT_W-1:0];
	localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

	// map a 2-bit non-volatile selector onto a level code
	function [4:0] nvm_code;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: nvm_code = `LRC_NVM_CODE0;
				2'h1: nvm_code = `LRC_NVM_CODE1;
				2'h2: nvm_code = `LRC_NVM_CODE2;
				default: nvm_code = `LRC_NVM_CODE3;
			endcase
		end
	endfunction

	// level code to millivolts for one regulator kind
	function [11:0] level_mv;
		input [4:0] code;
		input [1:0] kind;
		reg [11:0] steps;
		reg [11:0] v;
		begin
			steps = `LRC_MV_STEP * {7'h00, code};
			v = `LRC_MV_BASE;
			case (kind)
				`LRC_KIND_WIDE: begin
					// wide range climbs from its own base and caps at the top
					if (code > `LRC_CODE_CAP)
						v = `LRC_MV_TOP;
					else
						v = `LRC_MV_WBASE + steps;
				end
				`LRC_KIND_FIX: v = `LRC_MV_TOP;
				default: begin
					// up to the flat point every code gives the floor level
					if (code > `LRC_CODE_FLAT)
						v = `LRC_MV_BASE + steps - `LRC_MV_STEP * 12'h008;
					if (kind == `LRC_KIND_EXT && v > `LRC_MV_ETOP)
						v = `LRC_MV_ETOP;
					if (kind == `LRC_KIND_GEN && v > `LRC_MV_TOP)
						v = `LRC_MV_TOP;
				end
			endcase
			level_mv = v;
		end
	endfunction

	// electrical kind of regulator idx, which picks its level table
	function [1:0] reg_kind;
		input integer idx;
		begin
			if (idx == `LRC_WIDE_IDX)
				reg_kind = `LRC_KIND_WIDE;
			else if (idx == `LRC_EXT_IDX)
				reg_kind = `LRC_KIND_EXT;
			else if (idx == `LRC_PHY_IDX)
				reg_kind = `LRC_KIND_FIX;
			else
				reg_kind = `LRC_KIND_GEN;
		end
	endfunction

	// synchroniser stages: only the second stage of each pair is read
	reg mode_s1_reg;
	reg mode_s2_reg;
	reg [5:0] oc_s1_reg;
	reg [5:0] oc_s2_reg;
	reg sink_s1_reg;
	reg sink_s2_reg;
	reg lim_s1_reg;
	reg lim_s2_reg;

	// non-volatile defaults latched on the loader pulse
	reg [11:0] nvm_lvl_reg;
	reg nvm_switch_reg;

	// debounce counters and their next values
	reg [CNT_W-1:0] cnt_reg [0:5];
	reg [CNT_W-1:0] cnt_next [0:5];

	// next values of the output registers
	reg [5:0] en_next;
	reg [29:0] code_next;
	reg [71:0] mv_next;
	reg [6:0] dis_next;
	reg [5:0] irq_next;
	reg byp_next;
	reg sink_next;
	reg [1:0] src_next;

	// scratch of the decode and debounce loops
	reg [7:0] sel_ctrl;
	reg [1:0] kind;
	reg oc_act;

	// one loop index per process, so no index has two drivers
	integer i;
	integer j;
	integer m;

	// two-flop synchronisers for the mode pin and the analog flags;
	// one synchronised mode bit steers every regulator, so none can lag
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_s1_reg <= 1'b0;
			mode_s2_reg <= 1'b0;
			oc_s1_reg <= 6'h00;
			oc_s2_reg <= 6'h00;
			sink_s1_reg <= 1'b0;
			sink_s2_reg <= 1'b0;
			lim_s1_reg <= 1'b0;
			lim_s2_reg <= 1'b0;
		end else begin
			mode_s1_reg <= power_mode_pin_i;
			mode_s2_reg <= mode_s1_reg;
			oc_s1_reg <= oc_source_i;
			oc_s2_reg <= oc_s1_reg;
			sink_s1_reg <= mm_sink_oc_i;
			sink_s2_reg <= sink_s1_reg;
			lim_s1_reg <= memref_limit_i;
			lim_s2_reg <= lim_s1_reg;
		end
	end

	// capture non-volatile defaults when the loader pulses
	// the values hold after the pulse; reset gives selector 0 and no bypass
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			nvm_lvl_reg <= 12'h000;
			nvm_switch_reg <= 1'b0;
		end else if (nvm_load_i) begin
			nvm_lvl_reg <= nvm_default_level_i;
			nvm_switch_reg <= nvm_switch_default_i;
		end
	end

	// per-regulator enable, level and mode selection
	always @* begin
		en_next = 6'h00;
		code_next = 30'h00000000;
		mv_next = 72'h0;
		sel_ctrl = 8'h00;
		kind = `LRC_KIND_GEN;
		byp_next = 1'b0;
		sink_next = 1'b0;
		for (i = 0; i < `LRC_NUM_REG; i = i + 1) begin
			// one synchronised selection steers every regulator
			if (mode_s2_reg)
				sel_ctrl = alternate_ctrl_reg_i[i*8 +: 8];
			else
				sel_ctrl = primary_ctrl_reg_i[i*8 +: 8];
			// while the sequencer runs it owns enables and levels outright
			if (seq_active_i) begin
				en_next[i] = seq_on_i[i];
				code_next[i*5 +: 5] = nvm_code(nvm_lvl_reg[i*2 +: 2]);
			end else begin
				en_next[i] = sel_ctrl[`LRC_ON_BIT];
				code_next[i*5 +: 5] = sel_ctrl[`LRC_LVL_LSB +: `LRC_LVL_W];
			end
			// only the multimode regulator has bypass and sink/source modes
			if (i == `LRC_MM_IDX) begin
				if (seq_active_i)
					byp_next = nvm_switch_reg;
				else
					byp_next = sel_ctrl[`LRC_BYPASS_BIT];
				// bypass overrides whatever the code holds
				sink_next = !byp_next && code_next[i*5 +: 5] == `LRC_SINK_CODE;
			end
			// the level table depends on the regulator kind
			kind = reg_kind(i);
			mv_next[i*12 +: 12] = level_mv(code_next[i*5 +: 5], kind);
		end
	end

	// discharge follows disable unless software inhibits it
	// the memory reference has its own enable and inhibit bit
	always @* begin
		dis_next[3:0] = ~en_next[3:0] & ~discharge_ctrl_a_i;
		dis_next[5:4] = ~en_next[5:4] & ~discharge_ctrl_b_i[1:0];
		dis_next[6] = ~memref_on_i & ~discharge_ctrl_b_i[2];
	end

	// overcurrent debounce per regulator
	// a flag that drops clears the count and the count saturates,
	// so each unbroken episode gives at most one pulse
	always @* begin
		irq_next = 6'h00;
		oc_act = 1'b0;
		for (j = 0; j < `LRC_NUM_REG; j = j + 1) begin
			oc_act = oc_s2_reg[j] & reg_enable_o[j];
			if (j == `LRC_MM_IDX) begin
				// sinking current counts only in sink/source mode
				oc_act = (oc_act | (sink_s2_reg & mm_sink_source_o & reg_enable_o[j]))
					& !mm_bypass_o;
			end
			if (!oc_act)
				cnt_next[j] = {CNT_W{1'b0}};
			else if (cnt_reg[j] != DB_CYC)
				cnt_next[j] = cnt_reg[j] + CNT_ONE;
			else
				cnt_next[j] = cnt_reg[j];
			irq_next[j] = oc_act && cnt_reg[j] == DB_CYC - CNT_ONE;
		end
	end

	// phy regulator picks the highest supply, lower index on a tie
	// readings are on this clock already, so no synchroniser is needed
	always @* begin
		src_next = `LRC_SRC_VIN;
		if (phy_vbus_mv_i > phy_vin_mv_i)
			src_next = `LRC_SRC_VBUS;
		if (phy_boost_mv_i > phy_vin_mv_i && phy_boost_mv_i > phy_vbus_mv_i)
			src_next = `LRC_SRC_BOOST;
	end

	// output registers
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_enable_o <= 6'h00;
			level_code_o <= 30'h00000000;
			level_mv_o <= 72'h0;
			alt_mode_o <= 1'b0;
			mm_bypass_o <= 1'b0;
			mm_sink_source_o <= 1'b0;
			discharge_o <= 7'h7f;
			overcurrent_irq_o <= 6'h00;
			memref_limit_o <= 1'b0;
			phy_supply_source_o <= 2'h0;
			restart_status_reg_o <= 8'h00;
			for (m = 0; m < `LRC_NUM_REG; m = m + 1)
				cnt_reg[m] <= {CNT_W{1'b0}};
		end else begin
			// regulator controls
			reg_enable_o <= en_next;
			level_code_o <= code_next;
			level_mv_o <= mv_next;
			alt_mode_o <= mode_s2_reg;
			mm_bypass_o <= byp_next;
			mm_sink_source_o <= sink_next;
			discharge_o <= dis_next;
			// interrupts and status
			overcurrent_irq_o <= irq_next;
			// limiting is visible but never an interrupt
			memref_limit_o <= lim_s2_reg;
			phy_supply_source_o <= src_next;
			restart_status_reg_o <= {6'h00, src_next};
			for (m = 0; m < `LRC_NUM_REG; m = m + 1)
				cnt_reg[m] <= cnt_next[m];
		end
	end

endmodule // lrc_ctrl

// file: rtl/lrc_map.vh
// constants for the linear regulator control block
`ifndef LRC_MAP_VH
`define LRC_MAP_VH
`define LRC_NUM_REG 6
`define LRC_CTRL_W 8
`define LRC_ON_BIT 0
`define LRC_LVL_LSB 2
`define LRC_LVL_W 5
`define LRC_BYPASS_BIT 7
`define LRC_MM_IDX 2
`define LRC_PHY_IDX 3
`define LRC_WIDE_IDX 5
`define LRC_EXT_IDX 4
`define LRC_SINK_CODE 5'h1f
`define LRC_NVM_CODE0 5'h08
`define LRC_NVM_CODE1 5'h09
`define LRC_NVM_CODE2 5'h0b
`define LRC_NVM_CODE3 5'h18
`define LRC_KIND_GEN 2'h0
`define LRC_KIND_EXT 2'h1
`define LRC_KIND_WIDE 2'h2
`define LRC_KIND_FIX 2'h3
`define LRC_MV_BASE 12'h6a4
`define LRC_MV_WBASE 12'h384
`define LRC_MV_STEP 12'h064
`define LRC_MV_TOP 12'hce4
`define LRC_MV_ETOP 12'hf3c
`define LRC_CODE_FLAT 5'h08
`define LRC_CODE_CAP 5'h18
`define LRC_SRC_VIN 2'h0
`define LRC_SRC_VBUS 2'h1
`define LRC_SRC_BOOST 2'h2
`define LRC_OC_DB_NS 1000
`define LRC_CLK_MHZ 25
`endif

// file: tb/lrc_ctrl_asserts.sv
// concurrent checks on the regulator control ports
`timescale 1ns/1ns
module lrc_ctrl_asserts (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire power_mode_pin_i,
	input wire [47:0] primary_ctrl_reg_i,
	input wire [47:0] alternate_ctrl_reg_i,
	input wire seq_active_i,
	input wire [3:0] discharge_ctrl_a_i,
	input wire [2:0] discharge_ctrl_b_i,
	input wire [5:0] oc_source_i,
	input wire mm_sink_oc_i,
	input wire [5:0] reg_enable_o,
	input wire [29:0] level_code_o,
	input wire alt_mode_o,
	input wire mm_bypass_o,
	input wire mm_sink_source_o,
	input wire [6:0] discharge_o,
	input wire [5:0] overcurrent_irq_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// software owned the regulators one cycle ago
	sequence s_sw;
		$past(arst_n_i) && !$past(seq_active_i);
	endsequence
	sequence s_pin_steady;
		(arst_n_i && $stable(power_mode_pin_i)) [*4];
	endsequence
	property p_sw_on;
		s_sw |-> reg_enable_o[0] == (alt_mode_o ? $past(alternate_ctrl_reg_i[0]) :
			$past(primary_ctrl_reg_i[0]));
	endproperty
	property p_sw_level;
		s_sw |-> level_code_o[14:10] == (alt_mode_o ? $past(alternate_ctrl_reg_i[22:18]) :
			$past(primary_ctrl_reg_i[22:18]));
	endproperty
	property p_pin;
		s_pin_steady |=> alt_mode_o == $past(power_mode_pin_i);
	endproperty
	// a pulse needs its flag seen high well before it
	property p_oc;
		(overcurrent_irq_o & ~(($past(oc_source_i, 4) & $past(oc_source_i, 5)) |
			{3'h0, $past(mm_sink_oc_i, 4) & $past(mm_sink_oc_i, 5), 2'h0})) == 6'h0;
	endproperty
	property p_sink;
		mm_sink_source_o == (level_code_o[14:10] == 5'h1f && !mm_bypass_o);
	endproperty
	property p_bypass_quiet;
		mm_bypass_o [*8] |-> !overcurrent_irq_o[2];
	endproperty
	property p_quiet;
		(oc_source_i == 6'h0 && !mm_sink_oc_i) [*8] |-> ##4 overcurrent_irq_o == 6'h0;
	endproperty
	property p_discharge;
		$past(arst_n_i) |-> discharge_o[5:0] == (~reg_enable_o &
			~{$past(discharge_ctrl_b_i[1:0]), $past(discharge_ctrl_a_i)});
	endproperty
	a_sw_on: assert property (p_sw_on) else $error("enable not from active set");
	a_sw_level: assert property (p_sw_level) else $error("code not from active set");
	a_pin: assert property (p_pin) else $error("mode select lost");
	a_oc: assert property (p_oc) else $error("interrupt without debounce");
	a_sink: assert property (p_sink) else $error("sink mode wrong");
	a_bypass_quiet: assert property (p_bypass_quiet) else $error("bypass interrupt");
	a_quiet: assert property (p_quiet) else $error("interrupt with no flag");
	a_discharge: assert property (p_discharge) else $error("discharge wrong");
endmodule // lrc_ctrl_asserts
bind lrc_ctrl lrc_ctrl_asserts lrc_ctrl_asserts_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
	.power_mode_pin_i(power_mode_pin_i), .primary_ctrl_reg_i(primary_ctrl_reg_i),
	.alternate_ctrl_reg_i(alternate_ctrl_reg_i), .seq_active_i(seq_active_i),
	.discharge_ctrl_a_i(discharge_ctrl_a_i), .discharge_ctrl_b_i(discharge_ctrl_b_i),
	.oc_source_i(oc_source_i), .mm_sink_oc_i(mm_sink_oc_i), .reg_enable_o(reg_enable_o),
	.level_code_o(level_code_o), .alt_mode_o(alt_mode_o), .mm_bypass_o(mm_bypass_o),
	.mm_sink_source_o(mm_sink_source_o), .discharge_o(discharge_o),
	.overcurrent_irq_o(overcurrent_irq_o));

// file: tb/lrc_host_model.sv
// host side model: control register images and the mode pin
`timescale 1ns/1ns
module lrc_host_model (
	input wire core_clk_i,
	output reg [47:0] primary_ctrl_reg_o,
	output reg [47:0] alternate_ctrl_reg_o,
	output reg power_mode_pin_o
);
	// idle host: all regulators off, main set selected
	initial begin
		primary_ctrl_reg_o = 48'h0;
		alternate_ctrl_reg_o = 48'h0;
		power_mode_pin_o = 1'b0;
	end
	// new images land just past an edge and then stay put
	task put(input [47:0] p, input [47:0] a, input s);
		begin
			@(posedge core_clk_i);
			#1;
			primary_ctrl_reg_o = p;
			alternate_ctrl_reg_o = a;
			power_mode_pin_o = s;
		end
	endtask
endmodule // lrc_host_model

// file: tb/testbench.sv
// random and directed bench for the regulator control block
`timescale 1ns/1ns
module testbench;
	reg clk = 1'b0, rst_n = 1'b0, seq = 1'b0, ld = 1'b0, sw = 1'b0, mon = 1'b0;
	reg snk = 1'b0, lim = 1'b0;
	reg [5:0] son = 6'h0, oc = 6'h0, acc;
	reg [11:0] nvl = 12'h0;
	reg [3:0] da = 4'h0;
	reg [2:0] db = 3'h0;
	reg [9:0] v0 = 10'h0, v1 = 10'h0, v2 = 10'h0;
	reg [47:0] p, act;
	wire [47:0] pri, alt;
	wire pin, altm, byp, sks, liml;
	wire [5:0] en, irq;
	wire [5:0] dsel = {db[1:0], da};
	wire [29:0] code;
	wire [71:0] mv;
	wire [6:0] dis;
	wire [1:0] src;
	wire [7:0] rsr;
	integer seed = 32'hbc61, err_total = 0, n_checks = 0, k, i, n;
	lrc_host_model lrc_host_model_i (.core_clk_i(clk), .primary_ctrl_reg_o(pri),
		.alternate_ctrl_reg_o(alt), .power_mode_pin_o(pin));
	lrc_ctrl #(.OC_DB_NS(200)) lrc_ctrl_i (.core_clk_i(clk), .arst_n_i(rst_n),
		.power_mode_pin_i(pin), .primary_ctrl_reg_i(pri), .alternate_ctrl_reg_i(alt),
		.seq_active_i(seq), .seq_on_i(son), .nvm_load_i(ld), .nvm_default_level_i(nvl),
		.nvm_switch_default_i(sw), .discharge_ctrl_a_i(da), .discharge_ctrl_b_i(db),
		.memref_on_i(mon), .oc_source_i(oc), .mm_sink_oc_i(snk), .memref_limit_i(lim),
		.phy_vin_mv_i(v0), .phy_vbus_mv_i(v1), .phy_boost_mv_i(v2), .reg_enable_o(en),
		.level_code_o(code), .level_mv_o(mv), .alt_mode_o(altm), .mm_bypass_o(byp),
		.mm_sink_source_o(sks), .discharge_o(dis), .overcurrent_irq_o(irq),
		.memref_limit_o(liml), .phy_supply_source_o(src), .restart_status_reg_o(rsr));
	// 25 MHz clock
	always #20 clk = ~clk;
	// expected millivolts of regulator r at code c
	function [11:0] mv_of(input integer r, input [4:0] c);
		reg [11:0] top;
		begin
			top = (r == 4) ? 12'hf3c : 12'hce4;
			mv_of = (r == 5) ? 12'h384 + 12'h64 * c : 12'h6a4 + 12'h64 * (c < 5'h08 ? 5'h0 : c - 5'h08);
			if (r == 3 || mv_of > top)
				mv_of = (r == 3) ? 12'hce4 : top;
		end
	endfunction
	function [4:0] nvm_code(input [1:0] s);
		nvm_code = (s == 2'h0) ? 5'h08 : (s == 2'h1) ? 5'h09 : (s == 2'h2) ? 5'h0b : 5'h18;
	endfunction
	function [1:0] src_of(input [9:0] x, input [9:0] y, input [9:0] z);
		src_of = (x >= y && x >= z) ? 2'h0 : (y >= z) ? 2'h1 : 2'h2;
	endfunction
	task step(input integer c);
		begin
			repeat (c) @(posedge clk);
			#1;
		end
	endtask
	task chk(input [255:0] what, input [71:0] seen, input [71:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("MISMATCH %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// or together interrupts seen over c cycles
	task quiet(input integer c);
		begin
			acc = 6'h0;
			repeat (c) begin
				step(1);
				acc = acc | irq;
			end
		end
	endtask
	// bounded wait for one interrupt pulse after its flag rose
	task irq_lat(input integer b);
		begin
			for (n = 0; n < 12 && irq[b] !== 1'b1; n = n + 1)
				step(1);
			chk("irq latency", n >= 6 && n <= 8, 1);
			if (n == 12)
				complete_run;
		end
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		chk("reset discharge", dis, 7'h7f);
		#1 rst_n = 1'b1;
		for (k = 0; k < 24; k = k + 1) begin
			p = {$random(seed), $random(seed)};
			act = {$random(seed), $random(seed)};
			if (k % 3 == 0) begin
				p[22:18] = 5'h1f;
				act[22:18] = 5'h1f;
			end
			da = $random(seed);
			db = $random(seed);
			mon = $random(seed);
			lrc_host_model_i.put(p, act, k[1]);
			step(4);
			act = k[1] ? act : p;
			chk("alt mode", altm, k[1]);
			chk("bypass", byp, act[23]);
			chk("sink", sks, act[22:18] == 5'h1f && !act[23]);
			chk("discharge ref", dis[6], !mon && !db[2]);
			for (i = 0; i < 6; i = i + 1) begin
				chk("enable", en[i], act[8 * i]);
				chk("code", code[5 * i +: 5], act[8 * i + 2 +: 5]);
				chk("millivolts", mv[12 * i +: 12], mv_of(i, act[8 * i + 2 +: 5]));
				chk("discharge", dis[i], !act[8 * i] && !dsel[i]);
			end
		end
		$display("software sets done");
		seq = 1'b1;
		for (k = 0; k < 4; k = k + 1) begin
			nvl = (k == 0) ? 12'he4 : $random(seed);
			sw = k[0];
			son = $random(seed);
			ld = 1'b1;
			step(1);
			ld = 1'b0;
			step(2);
			chk("seq enable", en, son);
			chk("nvm bypass", byp, sw);
			for (i = 0; i < 6; i = i + 1)
				chk("nvm code", code[5 * i +: 5], nvm_code(nvl[2 * i +: 2]));
		end
		seq = 1'b0;
		$display("sequencer done");
		lrc_host_model_i.put({6{8'h25}}, {6{8'h25}}, 1'b0);
		step(4);
		for (i = 0; i < 6; i = i + 1) begin
			oc[i] = 1'b1;
			irq_lat(i);
			quiet(8);
			chk("one pulse", acc, 6'h0);
			oc[i] = 1'b0;
			step(4);
		end
		p = {{3{8'h25}}, 8'h7d, {2{8'h25}}};
		lrc_host_model_i.put(p, p, 1'b0);
		step(4);
		snk = 1'b1;
		irq_lat(2);
		snk = 1'b0;
		p[23:16] = 8'hfd;
		lrc_host_model_i.put(p, p, 1'b0);
		step(4);
		oc[2] = 1'b1;
		snk = 1'b1;
		quiet(12);
		chk("bypass irq", acc, 6'h0);
		oc[2] = 1'b0;
		snk = 1'b0;
		lim = 1'b1;
		quiet(12);
		chk("memref irq", acc, 6'h0);
		chk("memref limit", liml, 1);
		$display("overcurrent done");
		for (k = 0; k < 12; k = k + 1) begin
			v0 = $random(seed);
			v1 = (k < 2) ? v0 : $random(seed);
			v2 = (k == 0) ? v0 : $random(seed);
			step(2);
			chk("phy source", src, src_of(v0, v1, v2));
			chk("restart status", rsr, {6'h0, src_of(v0, v1, v2)});
		end
		$display("phy source done");
		complete_run;
	end
endmodule // testbench
